/* verification/cmpctl_core_model.sv */
// behavioural model of the analogue comparator core
`timescale 1ns/1ps
module cmpctl_core_model (
	input  wire logic                       vin_above,
	input  wire cmpctl_pkg::cmpctl_analog_t cfg,
	output logic                            cmp_decision
);
	// an unpowered core gives no trustworthy level: show the inverse
	assign cmp_decision = cfg.enable ? vin_above : ~vin_above;
endmodule : cmpctl_core_model

/* verification/comparator_control_logic_tb.sv */
// self-checking bench for the comparator control logic
`timescale 1ns/1ps
module comparator_control_logic_tb;
	logic                       mclk;
	logic                       reset;
	logic                       vin;
	logic                       dec;
	logic                       s_out;
	logic                       r_out;
	logic                       irq;
	logic [7:0]                 ctrl;
	logic [1:0]                 mode;
	cmpctl_pkg::cmpctl_sw_t     sw;
	cmpctl_pkg::cmpctl_analog_t ana;
	int                         n_errors;
	int                         tests_run;
	// rows: {mode, control write}, all hysteresis codes on both fields
	logic [9:0] rows [4] = '{10'h081, 10'h186, 10'h28B, 10'h38C};

	cmpctl_top u_cmpctl_top (.mclk(mclk), .reset(reset),
		.cmp_decision(dec), .sw(sw), .comparator_sync_out(s_out),
		.comparator_raw_out(r_out), .comparator_control_reg(ctrl),
		.comparator_mode_reg(mode), .analog_cfg(ana), .cmp_irq(irq));
	cmpctl_core_model u_cmpctl_core_model (.vin_above(vin), .cfg(ana),
		.cmp_decision(dec));

	// free-running 200 MHz clock
	always #2.5 mclk = ~mclk;

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time,
				seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	// one-cycle write pulse, also ends any mode write pulse
	task automatic wr(input logic [7:0] d);
		@(posedge mclk);
		#1 sw.ctrl_we = 1'b1;
		sw.ctrl_wdata = d;
		step(1);
		sw.ctrl_we = 1'b0;
		sw.mode_we = 1'b0;
	endtask : wr

	task automatic print_verdict;
		$display("mismatches %0d of %0d checks", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		reset = 1'b1;
		vin = 1'b0;
		sw = '0;
		n_errors = 0;
		tests_run = 0;
		repeat (16) @(posedge mclk);
		#1 reset = 1'b0;
		check(ctrl, 8'h00);
		check({3'h0, mode, s_out, r_out, irq}, 8'h00);
		for (int i = 0; i < 4; i++) begin
			sw.mode_we = 1'b1;
			sw.mode_wdata = rows[i][9:8];
			wr(rows[i][7:0]);
			check({1'b0, ana}, {2'h1, rows[i][9:8], rows[i][3:0]});
			check(ctrl, rows[i][7:0]);
			check({6'h00, mode}, {6'h00, rows[i][9:8]});
		end
		// rising edge, mask first off then on
		vin = 1'b1;
		step(6);
		check(ctrl, 8'hEC);
		check({5'h00, s_out, r_out, irq}, 8'h06);
		sw.rise_mask = 1'b1;
		step(2);
		check({7'h00, irq}, 8'h01);
		// falling edge keeps the earlier rise flag
		vin = 1'b0;
		step(6);
		check(ctrl, 8'hBC);
		wr(8'h9C);
		check(ctrl, 8'h9C);
		step(2);
		check({7'h00, irq}, 8'h00);
		sw.fall_mask = 1'b1;
		step(2);
		check({7'h00, irq}, 8'h01);
		// raw output follows with no clock edge in between
		@(posedge mclk);
		#1 vin = 1'b1;
		#1 check({7'h00, r_out}, 8'h01);
		step(6);
		wr(8'h0C);
		step(2);
		check({6'h00, s_out, r_out}, 8'h00);
		// re-enable, let it settle, then clear stray flags
		wr(8'h8C);
		step(6);
		wr(8'h8C);
		check(ctrl, 8'hCC);
		// clear lands in the very cycle the rising edge counts
		vin = 1'b0;
		step(6);
		wr(8'h8C);
		vin = 1'b1;
		step(2);
		wr(8'h8C);
		check(ctrl, 8'hEC);
		// reset in mid-run: everything back to its reset value at once
		@(posedge mclk);
		#1 reset = 1'b1;
		#1 check(ctrl, 8'h00);
		check({1'b0, ana}, 8'h00);
		check({3'h0, mode, s_out, r_out, irq}, 8'h00);
		step(2);
		reset = 1'b0;
		step(6);
		check({3'h0, mode, s_out, r_out, irq}, 8'h00);
		print_verdict();
	end

	// watchdog well beyond the fewer than a hundred cycles of the sequence
	initial begin
		#20000;
		n_errors++;
		print_verdict();
	end
endmodule : comparator_control_logic_tb

/* verilog/cmpctl_defs.svh */
// constants for the comparator control logic: fields, resets, codes
`ifndef CMPCTL_DEFS_SVH
`define CMPCTL_DEFS_SVH

// ------------------------------------------------------------------
// control register layout
// ------------------------------------------------------------------
`define CMPCTL_CTRL_W        8
`define CMPCTL_BIT_ON        7
`define CMPCTL_BIT_RESULT    6
`define CMPCTL_BIT_RISE      5
`define CMPCTL_BIT_FALL      4
`define CMPCTL_HYP_HI        3
`define CMPCTL_HYP_LO        2
`define CMPCTL_HYN_HI        1
`define CMPCTL_HYN_LO        0
`define CMPCTL_CTRL_RESET    8'h00

// ------------------------------------------------------------------
// mode register layout
// ------------------------------------------------------------------
`define CMPCTL_MODE_W        2
`define CMPCTL_MODE_RESET    2'h0
`define CMPCTL_RISE_MASK_RST 1'h0
`define CMPCTL_FALL_MASK_RST 1'h0

// ------------------------------------------------------------------
// hysteresis codes
// ------------------------------------------------------------------
`define CMPCTL_HYS_OFF       2'h0
`define CMPCTL_HYS_5MV       2'h1
`define CMPCTL_HYS_10MV      2'h2
`define CMPCTL_HYS_20MV      2'h3

`endif

/* verilog/cmpctl_pkg.sv */
// types shared by the comparator control logic
package cmpctl_pkg;

	// hysteresis amount code
	typedef enum logic [1:0] {
		CMPCTL_HYS_OFF_E  = 2'h0,
		CMPCTL_HYS_5MV_E  = 2'h1,
		CMPCTL_HYS_10MV_E = 2'h2,
		CMPCTL_HYS_20MV_E = 2'h3
	} cmpctl_hys_t;

	// settings handed to the analogue core
	typedef struct packed {
		logic        enable;
		logic [1:0]  mode;
		cmpctl_hys_t pos_hys;
		cmpctl_hys_t neg_hys;
	} cmpctl_analog_t;

	// software write request
	typedef struct packed {
		logic       ctrl_we;
		logic [7:0] ctrl_wdata;
		logic       mode_we;
		logic [1:0] mode_wdata;
		logic       rise_mask;
		logic       fall_mask;
	} cmpctl_sw_t;

	// state of the block apart from the two registered interrupt masks
	typedef struct packed {
		logic [2:0]     sync;
		logic           filt;
		logic           latched;
		logic           rise_flag;
		logic           fall_flag;
		logic           irq;
		cmpctl_analog_t ana;
	} cmpctl_state_t;

endpackage : cmpctl_pkg

/* verilog/cmpctl_top.sv */
// control, edge flags and outputs around an on-chip voltage comparator
`timescale 1ns/1ps
`include "cmpctl_defs.svh"

// Overview of operation
// - two outputs: clock-latched copy and raw copy of the decision
// - raw output is combinational, works with the clock stopped
// - raw output forced low while the comparator is disabled, latched output from the next clock edge on
// - response-time mode held in a writable register, sent to core
// - control bits 3-0 hold negative and positive hysteresis fields
// - negative field picks off, 5 mV, 10 mV or 20 mV
// - positive field works the same way, independently
// - encoding 00 off, 01 5 mV, 10 10 mV, 11 20 mV
// - falling transition sets the falling-edge flag
// - rising transition sets the rising-edge flag
// - edge flags stay set until software writes zero
// - rising flag requests interrupt only when its mask is 1
// - falling flag requests interrupt only when its mask is 1
// - result bit shows the synchronised, filtered comparator output, four clock edges late
// - enable bit 1 turns comparator on, 0 turns it off
module cmpctl_top (
	input  wire logic                    mclk,
	input  wire logic                    reset,
	input  wire logic                    cmp_decision,
	input  wire cmpctl_pkg::cmpctl_sw_t  sw,
	output logic                         comparator_sync_out,
	output logic                         comparator_raw_out,
	output logic [7:0]                   comparator_control_reg,
	output logic [1:0]                   comparator_mode_reg,
	output cmpctl_pkg::cmpctl_analog_t   analog_cfg,
	output logic                         cmp_irq
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	cmpctl_pkg::cmpctl_state_t state_q;
	cmpctl_pkg::cmpctl_state_t state_d;
	logic                      rise_irq_mask_q;
	logic                      fall_irq_mask_q;
	logic                      rise_det;
	logic                      fall_det;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// latency from a change of the decision, counted in clock edges:
	//   edge 1  first stage takes the new level
	//   edge 2  second stage
	//   edge 3  third stage, stages two and three now agree
	//   edge 4  filtered value, result bit, latched output, edge flag
	//           and the interrupt request when the matching mask is set
	// a pulse shorter than two cycles may never reach agreement, so
	// short glitches from a slow or noisy core do not flag edges
	// the enable gate sits ahead of the chain, so switching the core
	// off looks like a falling edge when the decision was high

	// true when stages two and three agree on a level that the filter
	// does not hold yet, i.e. a change that now counts
	function automatic logic cmpctl_edge_to(
		input logic [2:0] sync,
		input logic       filt,
		input logic       level
	);
		cmpctl_edge_to = (sync[2] == level) && (sync[1] == level)
			&& (filt != level);
	endfunction : cmpctl_edge_to

	// next value of a sticky flag: a write of 0 clears, a write of 1
	// keeps; the edge is applied last so it survives a clear in the
	// same cycle and no event is ever lost
	function automatic logic cmpctl_flag_next(
		input logic cur,
		input logic we,
		input logic wbit,
		input logic hit
	);
		logic kept;
		kept = we ? (cur & wbit) : cur;
		cmpctl_flag_next = kept | hit;
	endfunction : cmpctl_flag_next

	// a change counts once the second and third stage agree
	assign rise_det = cmpctl_edge_to(state_q.sync, state_q.filt,
		1'b1);
	assign fall_det = cmpctl_edge_to(state_q.sync, state_q.filt, 1'b0);

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		// disabled core gives a low decision into the sync chain
		state_d.sync = {state_q.sync[1:0],
			cmp_decision & state_q.ana.enable};
		if (state_q.sync[2] == state_q.sync[1]) begin
			state_d.filt = state_q.sync[2];
		end
		state_d.latched = state_d.filt & state_q.ana.enable;
		// settings taken from a control write
		if (sw.ctrl_we) begin
			state_d.ana.enable = sw.ctrl_wdata[`CMPCTL_BIT_ON];
			state_d.ana.pos_hys = cmpctl_pkg::cmpctl_hys_t'(
				sw.ctrl_wdata[`CMPCTL_HYP_HI:`CMPCTL_HYP_LO]);
			state_d.ana.neg_hys = cmpctl_pkg::cmpctl_hys_t'(
				sw.ctrl_wdata[`CMPCTL_HYN_HI:`CMPCTL_HYN_LO]);
		end
		// set wins over a simultaneous software clear
		state_d.rise_flag = cmpctl_flag_next(state_q.rise_flag,
			sw.ctrl_we, sw.ctrl_wdata[`CMPCTL_BIT_RISE],
			rise_det);
		state_d.fall_flag = cmpctl_flag_next(state_q.fall_flag,
			sw.ctrl_we, sw.ctrl_wdata[`CMPCTL_BIT_FALL],
			fall_det);
		if (sw.mode_we) begin
			state_d.ana.mode = sw.mode_wdata;
		end
		state_d.irq = (state_d.rise_flag & sw.rise_mask)
			| (state_d.fall_flag & sw.fall_mask);
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_q         <= '0;
			rise_irq_mask_q <= `CMPCTL_RISE_MASK_RST;
			fall_irq_mask_q <= `CMPCTL_FALL_MASK_RST;
		end else begin
			state_q         <= state_d;
			rise_irq_mask_q <= sw.rise_mask;
			fall_irq_mask_q <= sw.fall_mask;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// raw path has no flop so it survives a stopped clock; the enable
	// gate comes from a flop that simply holds while the clock is off
	assign comparator_raw_out = cmp_decision & state_q.ana.enable;
	assign comparator_sync_out = state_q.latched;
	assign comparator_control_reg = {state_q.ana.enable,
		state_q.filt,
		state_q.rise_flag, state_q.fall_flag,
		state_q.ana.pos_hys, state_q.ana.neg_hys};
	assign comparator_mode_reg = state_q.ana.mode;
	assign analog_cfg = state_q.ana;
	assign cmp_irq = state_q.irq;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking ck @(posedge mclk); endclocking
	default disable iff (reset);

	AST_SYNC_LOW_OFF: assert property (
		!state_q.ana.enable |=> !comparator_sync_out)
		else $error("sync output high while disabled");
	AST_RAW_LOW_OFF: assert property (
		!state_q.ana.enable |-> !comparator_raw_out)
		else $error("raw output high while disabled");
	AST_RISE_SET: assert property (
		rise_det |=> state_q.rise_flag)
		else $error("rising edge did not set flag");
	AST_FALL_SET: assert property (
		fall_det |=> state_q.fall_flag)
		else $error("falling edge did not set flag");
	AST_RISE_STICKY: assert property (
		state_q.rise_flag && !(sw.ctrl_we
			&& !sw.ctrl_wdata[`CMPCTL_BIT_RISE]) |=> state_q.rise_flag)
		else $error("rise flag dropped without clear");
	AST_FALL_STICKY: assert property (
		state_q.fall_flag && !(sw.ctrl_we
			&& !sw.ctrl_wdata[`CMPCTL_BIT_FALL]) |=> state_q.fall_flag)
		else $error("fall flag dropped without clear");
	AST_IRQ_MASK: assert property (
		cmp_irq |-> (state_q.rise_flag && rise_irq_mask_q)
			|| (state_q.fall_flag && fall_irq_mask_q))
		else $error("interrupt without unmasked flag");
	AST_ENABLE_WR: assert property (
		sw.ctrl_we |=> state_q.ana.enable
			== $past(sw.ctrl_wdata[`CMPCTL_BIT_ON]))
		else $error("enable bit not written");
	AST_MODE_WR: assert property (
		sw.mode_we |=> comparator_mode_reg == $past(sw.mode_wdata))
		else $error("mode register not written");
	AST_LATCH_FOLLOWS: assert property (
		state_q.ana.enable && $stable(state_q.ana.enable)
			|=> comparator_sync_out == $past(state_d.filt))
		else $error("latched output does not follow decision");


	// ------------------------------------------------------------------
	// checks: synchroniser and edge flags
	// ------------------------------------------------------------------
	// an agreed high level shows in the result bit at the next edge
	AST_RESULT_HIGH: assert property (
		state_q.sync[2] && state_q.sync[1]
			|=> comparator_control_reg[`CMPCTL_BIT_RESULT])
		else $error("result bit missed a high level");

	// an agreed low level likewise
	AST_RESULT_LOW: assert property (
		!state_q.sync[2] && !state_q.sync[1]
			|=> !comparator_control_reg[`CMPCTL_BIT_RESULT])
		else $error("result bit missed a low level");

	// no flag comes up without a counted edge
	AST_NO_STRAY_RISE: assert property (
		!rise_det && !state_q.rise_flag |=> !state_q.rise_flag)
		else $error("rise flag set without an edge");

	// same for the falling side
	AST_NO_STRAY_FALL: assert property (
		!fall_det && !state_q.fall_flag |=> !state_q.fall_flag)
		else $error("fall flag set without an edge");

	// a disabled core feeds only lows into the chain
	AST_CHAIN_GATED: assert property (
		!state_q.ana.enable |=> !state_q.sync[0])
		else $error("chain took a level while disabled");

	// ------------------------------------------------------------------
	// checks: interrupt request
	// ------------------------------------------------------------------
	// both masks off: the request must be low next cycle
	AST_IRQ_QUIET: assert property (
		!sw.rise_mask && !sw.fall_mask |=> !cmp_irq)
		else $error("interrupt raised while both masks are off");

	// a held rising flag with its mask set must request
	AST_IRQ_RISE_ON: assert property (
		state_q.rise_flag && sw.rise_mask && !sw.ctrl_we |=> cmp_irq)
		else $error("unmasked rise flag gave no interrupt");

	// a held falling flag with its mask set must request
	AST_IRQ_FALL_ON: assert property (
		state_q.fall_flag && sw.fall_mask && !sw.ctrl_we |=> cmp_irq)
		else $error("unmasked fall flag gave no interrupt");

	// ------------------------------------------------------------------
	// checks: settings handed to the core
	// ------------------------------------------------------------------
	// positive hysteresis field taken from bits 3-2
	AST_POS_HYS_WR: assert property (
		sw.ctrl_we |=> analog_cfg.pos_hys
			== $past(sw.ctrl_wdata[`CMPCTL_HYP_HI:`CMPCTL_HYP_LO]))
		else $error("positive hysteresis not written");

	// negative hysteresis field taken from bits 1-0
	AST_NEG_HYS_WR: assert property (
		sw.ctrl_we |=> analog_cfg.neg_hys
			== $past(sw.ctrl_wdata[`CMPCTL_HYN_HI:`CMPCTL_HYN_LO]))
		else $error("negative hysteresis not written");

	// hysteresis holds between writes
	AST_HYS_HOLD: assert property (
		!sw.ctrl_we |=> $stable(analog_cfg.pos_hys)
			&& $stable(analog_cfg.neg_hys))
		else $error("hysteresis changed without a write");

	// response-time mode holds between writes
	AST_MODE_HOLD: assert property (
		!sw.mode_we |=> $stable(comparator_mode_reg))
		else $error("mode changed without a write");

	// enable holds between writes
	AST_ENABLE_HOLD: assert property (
		!sw.ctrl_we |=> $stable(state_q.ana.enable))
		else $error("enable changed without a write");

	// ------------------------------------------------------------------
	// checks: outputs
	// ------------------------------------------------------------------
	// raw copy tracks the decision with no clock in the path
	AST_RAW_FOLLOWS: assert property (
		state_q.ana.enable |-> comparator_raw_out == cmp_decision)
		else $error("raw output does not follow the decision");

	// latched output never high while the result bit reads low
	AST_SYNC_RESULT: assert property (
		comparator_sync_out
			|-> comparator_control_reg[`CMPCTL_BIT_RESULT])
		else $error("latched output disagrees with result bit");

	// main scenarios
	COV_RISE: cover property (rise_det ##1 state_q.rise_flag);
	COV_FALL: cover property (fall_det ##1 state_q.fall_flag);
	COV_IRQ: cover property (!cmp_irq ##1 cmp_irq);
	COV_OFF: cover property (state_q.ana.enable ##1 !state_q.ana.enable);
	COV_SET_WINS: cover property (rise_det && sw.ctrl_we
		&& !sw.ctrl_wdata[`CMPCTL_BIT_RISE]);

endmodule : cmpctl_top
